//--- rtl/spdg_pkg.sv
/*
 Package of the stepper pulse and direction generator: timing units, widths, state codes.
 Assumes a single 50 MHz system clock.
*/
package spdg_pkg;
    // ****************************************
    // Clock and time units
    // ****************************************
    localparam int CLK_PERIOD_PS = 20000;
    localparam int UNIT_TIME_PS = 100000;
    localparam int UNIT_CYCLES = (UNIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SWITCH_TIME_PS = 2000000;
    localparam int SWITCH_UNITS = (SWITCH_TIME_PS + UNIT_TIME_PS - 1) / UNIT_TIME_PS;
    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int TIME_W = 16;
    localparam int PRE_W = 4;
    localparam int CNT_W = 18;
    localparam logic [TIME_W-1:0] MIN_SETTING = 16'h0001;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] SWITCH_CNT = CNT_W'(SWITCH_UNITS);
    localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;

    typedef enum logic [2:0] {
        SPDG_IDLE = 3'b001,
        SPDG_ON = 3'b010,
        SPDG_OFF = 3'b100
    } spdg_state_type;
endpackage : spdg_pkg

//--- rtl/spdg_tick_if.sv
/*
 Interface carrying the 0.1 us tick between the prescaler and the generator.
 Assumes both ends share clk.
*/
`timescale 1ns/10ps
interface spdg_tick_if;
    logic tick;
    modport source (output tick);
    modport sink (input tick);
endinterface : spdg_tick_if

//--- rtl/spdg_prescaler.sv
/*
 Tick prescaler: one-cycle tick every 0.1 us of system clock.
 Assumes clk at the rate held in the package.
*/
`timescale 1ns/10ps
module spdg_prescaler
    import spdg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Tick out
    spdg_tick_if.source tk
);
    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic tick;
    } spdg_pre_type;

    spdg_pre_type pre_ff, nxt_pre;

    // ****************************************
    // Unit counter
    // ****************************************
    always_comb begin
        nxt_pre = pre_ff;
        nxt_pre.tick = 1'b0;
        if (pre_ff.cnt == PRE_LAST) begin
            nxt_pre.cnt = '0;
            nxt_pre.tick = 1'b1;
        end else begin
            nxt_pre.cnt = pre_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= nxt_pre;
        end
    end

    assign tk.tick = pre_ff.tick;

    tick_period_a: assert property (@(posedge clk) disable iff (!arst_n)
        pre_ff.tick |=> !pre_ff.tick [*4] ##1 pre_ff.tick)
        else $error("prescaler tick period wrong");
endmodule : spdg_prescaler

//--- rtl/spdg_gen.sv
/*
 Stepper pulse and direction generator: turns step requests with a direction into a
 timed step pulse and direction level on the two fast outputs.
 Assumes a single clock; step_req is a one-cycle pulse from logic on the same clock.
*/
// Function
// - Each pulse stays active for at least the on time and inactive for the off time.
// - After a direction change the next pulse waits at least the direction delay.
// - Pulse and direction polarity are each selectable high or low active.
// - On, off and delay times take a minimum of one 0.1 us unit at one-unit resolution.
// - The pulse always drives the first fast output and direction the second.
// - Each edge of the fast outputs is allowed a switching time of 2 us.
// - Pulses are spaced at least two switching times plus on plus off time.
// - The first pulse after a direction change waits one switching time plus the delay.
`timescale 1ns/10ps
module spdg_gen
    import spdg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Motion request
    input wire logic step_req,
    input wire logic step_dir,
    output logic step_busy,
    // Configuration in 0.1 us units
    input wire logic [TIME_W-1:0] on_time,
    input wire logic [TIME_W-1:0] off_time,
    input wire logic [TIME_W-1:0] dir_delay,
    input wire logic pulse_active_low,
    input wire logic dir_active_low,
    // Fast outputs
    output logic step_pulse_output,
    output logic step_direction_output
);
    typedef struct packed {
        spdg_state_type st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] dly;
        logic pend;
        logic pend_dir;
        logic dir;
        logic pulse;
    } spdg_gen_type;

    spdg_gen_type s_ff, nxt_s;
    spdg_tick_if tk ();

    spdg_prescaler u_pre (
        .clk(clk),
        .arst_n(arst_n),
        .tk(tk)
    );

    // Settings below one unit are raised to the least legal value
    function automatic logic [CNT_W-1:0] units(input logic [TIME_W-1:0] v);
        logic [TIME_W-1:0] c;
        c = (v < MIN_SETTING) ? MIN_SETTING : v;
        return CNT_W'(c);
    endfunction : units

    // ****************************************
    // Step sequencer
    // ****************************************
    always_comb begin
        nxt_s = s_ff;
        if (step_req) begin
            nxt_s.pend = 1'b1;
            nxt_s.pend_dir = step_dir;
        end
        if (tk.tick && s_ff.cnt != CNT_ZERO) begin
            nxt_s.cnt = s_ff.cnt - 1'b1;
        end
        if (tk.tick && s_ff.dly != CNT_ZERO) begin
            nxt_s.dly = s_ff.dly - 1'b1;
        end
        case (s_ff.st)
            SPDG_IDLE: begin
                if (s_ff.pend && s_ff.pend_dir != s_ff.dir) begin
                    // Direction settles first; the pulse waits for it
                    nxt_s.dir = s_ff.pend_dir;
                    nxt_s.dly = SWITCH_CNT + units(dir_delay);
                end else if (s_ff.pend && s_ff.dly == CNT_ZERO) begin
                    nxt_s.pend = step_req;
                    nxt_s.pulse = 1'b1;
                    nxt_s.st = SPDG_ON;
                    nxt_s.cnt = SWITCH_CNT + units(on_time);
                end
            end
            SPDG_ON: begin
                if (s_ff.cnt == CNT_ZERO) begin
                    nxt_s.pulse = 1'b0;
                    nxt_s.st = SPDG_OFF;
                    nxt_s.cnt = SWITCH_CNT + units(off_time);
                end
            end
            SPDG_OFF: begin
                if (s_ff.cnt == CNT_ZERO) begin
                    nxt_s.st = SPDG_IDLE;
                end
            end
            default: begin
                nxt_s.st = SPDG_IDLE;
                nxt_s.pulse = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '{st: SPDG_IDLE, cnt: CNT_ZERO, dly: CNT_ZERO, default: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Polarity is applied on the registered level; a polarity change mid-pulse glitches
    assign step_pulse_output = s_ff.pulse ^ pulse_active_low;
    assign step_direction_output = s_ff.dir ^ dir_active_low;
    assign step_busy = s_ff.pend || s_ff.st != SPDG_IDLE;

    // ****************************************
    // Checks
    // ****************************************
    // The 99-cycle bounds are twenty switch units of five clocks, less one for tick alignment
    pulse_on_min_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_ff.pulse) |-> s_ff.pulse [*8])
        else $error("pulse on time too short");
    pulse_off_min_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(s_ff.pulse) |-> !s_ff.pulse [*8])
        else $error("pulse off time too short");
    on_len_min_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_ff.pulse) |-> ##99 s_ff.pulse)
        else $error("pulse on phase shorter than switch time");
    off_len_min_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(s_ff.pulse) |-> ##99 !s_ff.pulse)
        else $error("pulse off phase shorter than switch time");
    on_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_ff.pulse) |-> s_ff.cnt > SWITCH_CNT)
        else $error("on time not loaded");
    off_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(s_ff.pulse) |-> s_ff.cnt > SWITCH_CNT)
        else $error("off time not loaded");
    state_onehot_a: assert property (@(posedge clk) disable iff (!arst_n)
        $onehot(s_ff.st))
        else $error("sequencer state not one-hot");
    pulse_state_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.pulse == (s_ff.st == SPDG_ON))
        else $error("pulse level disagrees with state");
    on_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.st == SPDG_ON && s_ff.cnt != CNT_ZERO |=> s_ff.pulse)
        else $error("pulse ended before on count ran out");
    off_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.st == SPDG_OFF && s_ff.cnt != CNT_ZERO |=> !s_ff.pulse && s_ff.st == SPDG_OFF)
        else $error("off phase ended before off count ran out");
    on_count_tick_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.st == SPDG_ON && !tk.tick |=> s_ff.st != SPDG_ON || $stable(s_ff.cnt))
        else $error("on count moved without a tick");
    dly_count_tick_a: assert property (@(posedge clk) disable iff (!arst_n)
        !tk.tick |=> $stable(s_ff.dly) || $changed(s_ff.dir))
        else $error("delay count moved without a tick");

    // ****************************************
    // Direction checks
    // ****************************************
    dir_hold_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(s_ff.dir) |-> !s_ff.pulse [*8])
        else $error("pulse too soon after direction change");
    dir_len_min_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(s_ff.dir) |-> ##99 !s_ff.pulse)
        else $error("pulse sooner than switch time after direction change");
    dir_stable_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.pulse |-> $stable(s_ff.dir))
        else $error("direction changed during pulse");
    dly_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(s_ff.dir) |-> s_ff.dly >= SWITCH_CNT + 18'h00001)
        else $error("direction delay not loaded");
    idle_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.st == SPDG_IDLE && s_ff.dly != CNT_ZERO |=> !s_ff.pulse)
        else $error("pulse launched while direction delay runs");
    launch_dly_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_ff.pulse) |-> s_ff.dly == CNT_ZERO)
        else $error("pulse launched before direction delay expired");
    dir_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(s_ff.dir) |-> s_ff.st == SPDG_IDLE && !s_ff.pulse)
        else $error("direction changed outside idle");
    dir_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.pend && s_ff.st == SPDG_IDLE && s_ff.pend_dir != s_ff.dir
        |=> s_ff.dir == $past(s_ff.pend_dir))
        else $error("direction level did not follow request");
    polarity_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.st != SPDG_ON |-> step_pulse_output == pulse_active_low)
        else $error("pulse polarity wrong");
    dir_polarity_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(s_ff.dir) && $stable(dir_active_low) |-> $changed(step_direction_output))
        else $error("direction change not on its output");

    // ****************************************
    // Request checks
    // ****************************************
    // Only one request is remembered; a second one while pending merges into it
    req_kept_a: assert property (@(posedge clk) disable iff (!arst_n)
        step_req |=> s_ff.pend || $rose(s_ff.pulse))
        else $error("step request dropped");
    pend_lat_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_ff.pend && s_ff.st == SPDG_IDLE && s_ff.dly == CNT_ZERO && s_ff.pend_dir == s_ff.dir
        |=> s_ff.pulse)
        else $error("pending step not issued");
    busy_req_a: assert property (@(posedge clk) disable iff (!arst_n)
        step_req |=> step_busy)
        else $error("busy not raised by a request");
    pend_refill_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_ff.pulse) |-> s_ff.pend == $past(step_req))
        else $error("request during launch lost");
    launch_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_ff.pulse) |-> s_ff.dir == $past(s_ff.pend_dir))
        else $error("pulse issued with stale direction");
endmodule : spdg_gen

//--- testbench/spdg_drive_model.sv
/*
 Stepper drive model: decodes pulse and direction, measures phase lengths.
 Assumes its polarity inputs match those given to the generator.
*/
`timescale 1ns/10ps
module spdg_drive_model (
    // Clock, fast outputs and polarity
    input wire logic clk,
    input wire logic pulse_in,
    input wire logic dir_in,
    input wire logic pulse_active_low,
    input wire logic dir_active_low,
    // Observations
    output logic seen,
    output logic fell,
    output logic seen_dir,
    output logic dir_moved,
    output int lo_len,
    output int hi_len,
    output int dir_len
);
    logic p_q = 1'b0;
    logic d_q = 1'b0;
    logic mv = 1'b0;
    int cnt = 0;
    int dcnt = 0;
    // Decoding with the live polarity keeps an idle polarity swap from looking like a step
    wire logic p = pulse_in ^ pulse_active_low;
    wire logic d = dir_in ^ dir_active_low;
    always @(posedge clk) begin
        seen <= p & ~p_q;
        fell <= p_q & ~p;
        cnt <= (p != p_q) ? 1 : cnt + 1;
        dcnt <= (d != d_q) ? 1 : dcnt + 1;
        if (d != d_q) mv <= 1'b1;
        if (p & ~p_q) begin
            lo_len <= cnt;
            dir_len <= dcnt;
            seen_dir <= d;
            dir_moved <= mv | (d != d_q);
            mv <= 1'b0;
        end
        if (p_q & ~p) hi_len <= cnt;
        p_q <= p;
        d_q <= d;
    end
endmodule : spdg_drive_model

//--- testbench/testbench.sv
/*
 Self-checking bench of the pulse and direction generator with a drive model.
 Assumes the 50 MHz clock and the tick of 5 cycles from the package.
*/
`timescale 1ns/10ps
module testbench;
    import spdg_pkg::*;
    logic clk = 1'b0, arst_n, step_req = 1'b0, step_dir = 1'b0;
    logic pulse_active_low = 1'b0, dir_active_low = 1'b0;
    logic [TIME_W-1:0] on_time = '0, off_time = '0, dir_delay = '0;
    logic step_busy, step_pulse_output, step_direction_output;
    logic seen, fell, seen_dir, dir_moved;
    int lo_len, hi_len, dir_len, lim, fails = 0, tests_run = 0;
    // No off phase precedes the first pulse of the run
    int off_ref = -19;
    logic [15:0] rng = 16'h407f;
    logic exp_q[$];
    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] xs(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction : xs
    // A setting of zero acts as one unit
    function automatic int eff(input logic [TIME_W-1:0] v);
        return (v == 16'h0000) ? 1 : int'(v);
    endfunction : eff
    task automatic chk(input string what, input logic ok, input logic [31:0] e, g);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic step(input logic d);
        step_req <= 1'b1;
        step_dir <= d;
        exp_q.push_back(d);
        @(posedge clk);
        step_req <= 1'b0;
    endtask : step
    initial forever #10 clk = ~clk;
    spdg_gen i_spdg_gen (.clk(clk), .arst_n(arst_n), .step_req(step_req), .step_dir(step_dir),
        .step_busy(step_busy), .on_time(on_time), .off_time(off_time), .dir_delay(dir_delay),
        .pulse_active_low(pulse_active_low), .dir_active_low(dir_active_low),
        .step_pulse_output(step_pulse_output), .step_direction_output(step_direction_output));
    spdg_drive_model i_spdg_drive_model (.clk(clk), .pulse_in(step_pulse_output),
        .dir_in(step_direction_output), .pulse_active_low(pulse_active_low),
        .dir_active_low(dir_active_low), .seen(seen), .fell(fell), .seen_dir(seen_dir),
        .dir_moved(dir_moved), .lo_len(lo_len), .hi_len(hi_len), .dir_len(dir_len));
    // ****************
    // Watcher: lower bounds allow one tick of alignment slack
    // ****************
    always @(posedge clk) begin
        if (seen) begin
            chk("step dir", exp_q.size() > 0 && seen_dir === exp_q[0], 1, seen_dir);
            if (exp_q.size() > 0) void'(exp_q.pop_front());
            chk("off len", lo_len >= (19 + off_ref) * 5, 0, lo_len);
            if (dir_moved)
                chk("dir len", dir_len >= (19 + eff(dir_delay)) * 5, 0, dir_len);
        end
        if (fell) begin
            chk("on len", hi_len >= (19 + eff(on_time)) * 5, 0, hi_len);
            // The off phase that follows was loaded with this setting
            off_ref = eff(off_time);
        end
    end
    // ****************
    // Stimulus
    // ****************
    initial begin
        arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            rng = xs(rng);
            pulse_active_low <= k[0];
            dir_active_low <= k[1];
            on_time <= 16'(rng[3:2]);
            off_time <= 16'(rng[5:4]);
            dir_delay <= 16'(rng[7:6]);
            @(posedge clk);
            step(rng[8]);
            @(negedge clk);
            chk("busy", step_busy === 1'b1, 1, step_busy);
            lim = 0;
            while ((step_pulse_output ^ pulse_active_low) !== 1'b1 && lim < 1000) begin
                @(posedge clk);
                lim++;
            end
            chk("pulse wait", lim < 1000, 1000, lim);
            step(rng[9]);
            lim = 0;
            while (step_busy !== 1'b0 && lim < 2000) begin
                @(posedge clk);
                lim++;
            end
            chk("busy wait", lim < 2000, 2000, lim);
            @(posedge clk);
            chk("idle pulse", step_pulse_output === pulse_active_low, 0, 0);
            chk("idle dir", step_direction_output === (rng[9] ^ dir_active_low), 0, 0);
        end
        chk("steps left", exp_q.size() == 0, 0, exp_q.size());
        conclude();
    end
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule : testbench
